// file: dtbw_pkg.sv
// Constants, types and register map of the dual timer, tone output and watchdog block
package dtbw_pkg;

   // Register offsets on the 4-bit register port
   localparam logic [3:0] OFF_CNT_LO0 = 4'h0;
   localparam logic [3:0] OFF_CNT_HI0 = 4'h1;
   localparam logic [3:0] OFF_CNT_LO1 = 4'h2;
   localparam logic [3:0] OFF_CNT_HI1 = 4'h3;
   localparam logic [3:0] OFF_TMODE   = 4'h4;
   localparam logic [3:0] OFF_TCTL    = 4'h5;
   localparam logic [3:0] OFF_TBASE   = 4'h6;
   localparam logic [3:0] OFF_BUZ     = 4'h7;
   localparam logic [3:0] OFF_WATCHDOG_CONTROL   = 4'h8;
   localparam logic [3:0] OFF_CLOCK_CONTROL   = 4'h9;

   // Values after reset
   localparam logic [7:0] RST_BYTE = 8'h00;

   // Field positions
   localparam int unsigned TM_FIELD_W = 4;
   localparam int unsigned TM_CT_BIT  = 2;
   localparam int unsigned TM_GATE_BIT = 3;
   localparam int unsigned TC_RUN_LSB = 0;
   localparam int unsigned TC_OVF_LSB = 4;
   localparam int unsigned TB_FIELD_W = 2;
   localparam int unsigned BZ_SEL_BIT = 6;
   localparam int unsigned BZ_EN_BIT  = 7;
   localparam int unsigned WD_RWT_BIT = 0;
   localparam int unsigned WD_EWT_BIT = 1;
   localparam int unsigned WD_RFLG_BIT = 2;
   localparam int unsigned WD_IRQ_BIT = 3;
   localparam int unsigned WD_RUN_BIT = 7;
   localparam int unsigned CK_INT_LSB = 6;

   // Pin positions inside the synchronised pin vector
   localparam int unsigned PIN_CNT_LSB = 0;
   localparam int unsigned PIN_IRQ_LSB = 2;
   localparam int unsigned PIN_SUB     = 4;

   // Cycle counts
   localparam int unsigned MC_CLKS = 4;
   localparam logic [1:0]  PHASE2_CODE = 2'h1;
   localparam logic [9:0]  DIV4_MASK    = 10'h003;
   localparam logic [9:0]  DIV64_MASK   = 10'h03F;
   localparam logic [9:0]  DIV1024_MASK = 10'h3FF;
   localparam int unsigned DOG_GRACE_CLKS = 512;
   localparam int unsigned DOG_RST_CLKS   = 2 * MC_CLKS;
   localparam int unsigned DOG_CLKS_0 = 4096;
   localparam int unsigned DOG_CLKS_1 = 32768;
   localparam int unsigned DOG_CLKS_2 = 262144;
   localparam int unsigned DOG_CLKS_3 = 2097152;

   typedef enum logic [1:0] {
      DTBW_M13  = 2'b00,
      DTBW_M16  = 2'b01,
      DTBW_MRLD = 2'b10,
      DTBW_MHLD = 2'b11
   } dtbw_mode_t;

   typedef enum logic [1:0] {
      DOG_IDLE  = 2'b00,
      DOG_COUNT = 2'b01,
      DOG_GRACE = 2'b10,
      DOG_RESET = 2'b11
   } dtbw_dog_t;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
      logic       ovf;
   } dtbw_step_t;

   typedef struct packed {
      logic sub_osc_clock;
      logic ext_irq_pin_n_1;
      logic ext_irq_pin_n_0;
      logic count_input_1;
      logic count_input_0;
   } dtbw_pins_t;

endpackage

// file: dtbw_top.sv
// Two timer/counters, tone output and watchdog behind a plain register port
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module dtbw_top #(
   parameter int unsigned DOG_INT0 = dtbw_pkg::DOG_CLKS_0,
   parameter int unsigned DOG_INT1 = dtbw_pkg::DOG_CLKS_1,
   parameter int unsigned DOG_INT2 = dtbw_pkg::DOG_CLKS_2,
   parameter int unsigned DOG_INT3 = dtbw_pkg::DOG_CLKS_3
) (
   input  wire logic                 clk,
   input  wire logic                 rstn,
   input  wire logic [3:0]           bus_addr,
   input  wire logic [7:0]           bus_wdata,
   input  wire logic                 bus_wr,
   input  wire logic                 bus_rd,
   output logic      [7:0]           bus_rdata,
   input  wire dtbw_pkg::dtbw_pins_t pins,
   input  wire logic                 ta_permit,
   input  wire logic [1:0]           ovf_ack,
   input  wire logic                 dog_irq_en,
   input  wire logic                 global_irq_en,
   input  wire logic                 key_tone,
   output logic      [1:0]           overflow_flag,
   output logic                      dog_irq_req,
   output logic                      dog_sys_reset,
   output logic                      tone_out_pin,
   output logic                      tone_out_oe
);

   function automatic logic div_tick(input logic [9:0] cnt, input logic [9:0] mask);
      div_tick = ((cnt & mask) == mask);
   endfunction

   function automatic dtbw_pkg::dtbw_step_t timer_step(input dtbw_pkg::dtbw_mode_t mode,
                                                       input logic [7:0] hi, input logic [7:0] lo);
      dtbw_pkg::dtbw_step_t s;
      s.hi  = hi;
      s.lo  = lo;
      s.ovf = 1'b0;
      case (mode)
         dtbw_pkg::DTBW_M13: begin
            // Upper three low bits never count
            s.lo = {lo[7:5], lo[4:0] + 5'h01};
            if (lo[4:0] == 5'h1F) begin
               s.hi  = hi + 8'h01;
               s.ovf = (hi == 8'hFF);
            end
         end
         dtbw_pkg::DTBW_M16: begin
            {s.hi, s.lo} = {hi, lo} + 16'h0001;
            s.ovf = ({hi, lo} == 16'hFFFF);
         end
         dtbw_pkg::DTBW_MRLD: begin
            if (lo == 8'hFF) begin
               s.lo  = hi;
               s.ovf = 1'b1;
            end else begin
               s.lo = lo + 8'h01;
            end
         end
         default: begin
            s.ovf = 1'b0;
         end
      endcase
      timer_step = s;
   endfunction

   // Register file
   logic [7:0]      tmode_reg;
   logic [7:0]      tbase_reg;
   logic [1:0]      run_reg;
   logic [1:0]      flag_reg;
   logic            buz_en_reg;
   logic            buz_sel_reg;
   logic [1:0]      dog_int_reg;
   logic            dog_run_reg;
   logic            dog_irq_flag_reg;
   logic            dog_reset_flag_reg;
   logic            ewt_reg;
   logic            rwt_reg;
   logic [7:0]      rdata_reg;
   logic [7:0]      cnt_lo_reg [2];
   logic [7:0]      cnt_hi_reg [2];
   logic [1:0]      pend_reg;

   // Pin synchronisers: stage one feeds stage two only
   logic [4:0]      sync1_reg;
   logic [4:0]      sync2_reg;
   logic [4:0]      sync3_reg;
   logic [9:0]      presc_reg;
   logic            buzz_reg;
   logic            tone_reg;
   logic            dog_rst_reg;

   wire             tick4    = div_tick(presc_reg, dtbw_pkg::DIV4_MASK);
   wire             tick64   = div_tick(presc_reg, dtbw_pkg::DIV64_MASK);
   wire             tick1024 = div_tick(presc_reg, dtbw_pkg::DIV1024_MASK);
   wire             tick_sub = sync3_reg[dtbw_pkg::PIN_SUB] & ~sync2_reg[dtbw_pkg::PIN_SUB];
   wire             phase2   = (presc_reg[1:0] == dtbw_pkg::PHASE2_CODE);

   wire             wr_lo0  = bus_wr & (bus_addr == dtbw_pkg::OFF_CNT_LO0);
   wire             wr_hi0  = bus_wr & (bus_addr == dtbw_pkg::OFF_CNT_HI0);
   wire             wr_lo1  = bus_wr & (bus_addr == dtbw_pkg::OFF_CNT_LO1);
   wire             wr_hi1  = bus_wr & (bus_addr == dtbw_pkg::OFF_CNT_HI1);
   wire             wr_tmod = bus_wr & (bus_addr == dtbw_pkg::OFF_TMODE);
   wire             wr_tctl = bus_wr & (bus_addr == dtbw_pkg::OFF_TCTL);
   wire             wr_tb   = bus_wr & (bus_addr == dtbw_pkg::OFF_TBASE);
   wire             wr_buz  = bus_wr & (bus_addr == dtbw_pkg::OFF_BUZ);
   wire             wr_wd   = bus_wr & (bus_addr == dtbw_pkg::OFF_WATCHDOG_CONTROL);
   wire             wr_ck   = bus_wr & (bus_addr == dtbw_pkg::OFF_CLOCK_CONTROL);
   wire             wr_wd_ok = wr_wd & ta_permit;
   wire [1:0]       wr_lo   = {wr_lo1, wr_lo0};
   wire [1:0]       wr_hi   = {wr_hi1, wr_hi0};

   logic [1:0]      cnt_en;
   logic [1:0]      cnt_tick;
   logic [1:0]      ovf_now;
   dtbw_pkg::dtbw_mode_t t_mode [2];

   for (genvar g = 0; g < 2; g++) begin : g_tmr
      wire [3:0]  mf   = tmode_reg[g * dtbw_pkg::TM_FIELD_W +: dtbw_pkg::TM_FIELD_W];
      wire [1:0]  tb   = tbase_reg[g * dtbw_pkg::TB_FIELD_W +: dtbw_pkg::TB_FIELD_W];
      wire        pin_fall = sync3_reg[dtbw_pkg::PIN_CNT_LSB + g] & ~sync2_reg[dtbw_pkg::PIN_CNT_LSB + g];
      wire        base_tick = (tb == 2'h0) ? tick4 : (tb == 2'h1) ? tick64 : (tb == 2'h2) ? tick1024 : tick_sub;
      wire        seen = pend_reg[g] | ovf_now[g];
      dtbw_pkg::dtbw_step_t nx;

      assign t_mode[g] = dtbw_pkg::dtbw_mode_t'(mf[1:0]);
      assign cnt_en[g] = run_reg[g] & (~mf[dtbw_pkg::TM_GATE_BIT]
                         | sync2_reg[dtbw_pkg::PIN_IRQ_LSB + g]);
      assign cnt_tick[g] = cnt_en[g] & (mf[dtbw_pkg::TM_CT_BIT] ? pin_fall : base_tick);
      assign nx = timer_step(t_mode[g], cnt_hi_reg[g], cnt_lo_reg[g]);
      assign ovf_now[g] = cnt_tick[g] & nx.ovf;

      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            cnt_lo_reg[g] <= dtbw_pkg::RST_BYTE;
            cnt_hi_reg[g] <= dtbw_pkg::RST_BYTE;
            pend_reg[g]   <= 1'b0;
            flag_reg[g]   <= 1'b0;
         end else begin
            // A software write to a byte wins over the count
            cnt_lo_reg[g] <= wr_lo[g] ? bus_wdata : (cnt_tick[g] ? nx.lo : cnt_lo_reg[g]);
            cnt_hi_reg[g] <= wr_hi[g] ? bus_wdata : (cnt_tick[g] ? nx.hi : cnt_hi_reg[g]);
            // Single pending bit: extra overflows before phase 2 are lost
            pend_reg[g] <= phase2 ? 1'b0 : seen;
            if (phase2 && seen) begin
               flag_reg[g] <= 1'b1;
            end else if (wr_tctl) begin
               flag_reg[g] <= bus_wdata[dtbw_pkg::TC_OVF_LSB + g];
            end else if (ovf_ack[g]) begin
               flag_reg[g] <= 1'b0;
            end
         end
      end
   end

   // Watchdog sequencer
   dtbw_pkg::dtbw_dog_t dog_state_reg;
   dtbw_pkg::dtbw_dog_t dog_state_next;
   logic [21:0]     dog_cnt_reg;
   logic [21:0]     dog_cnt_next;
   logic [8:0]      grace_reg;
   logic [8:0]      grace_next;
   logic            dog_timeout;

   wire             restart = wr_wd_ok & bus_wdata[dtbw_pkg::WD_RWT_BIT];
   wire [21:0]      dog_last = (dog_int_reg == 2'h0) ? 22'(DOG_INT0 - 1) :
                               (dog_int_reg == 2'h1) ? 22'(DOG_INT1 - 1) :
                               (dog_int_reg == 2'h2) ? 22'(DOG_INT2 - 1) : 22'(DOG_INT3 - 1);
   wire [8:0]       grace_last = 9'(dtbw_pkg::DOG_GRACE_CLKS - 1);
   wire [8:0]       rst_last   = 9'(dtbw_pkg::DOG_RST_CLKS - 1);
   wire             enter_rst  = (dog_state_reg == dtbw_pkg::DOG_GRACE) && (dog_state_next == dtbw_pkg::DOG_RESET);

   always_comb begin
      dog_state_next = dog_state_reg;
      dog_cnt_next   = dog_cnt_reg + 22'h00_0001;
      grace_next     = grace_reg;
      dog_timeout    = 1'b0;
      case (dog_state_reg)
         dtbw_pkg::DOG_IDLE: begin
            dog_cnt_next = 22'h00_0000;
            grace_next   = 9'h000;
            if (dog_run_reg) begin
               dog_state_next = dtbw_pkg::DOG_COUNT;
            end
         end
         dtbw_pkg::DOG_COUNT: begin
            if (dog_cnt_reg == dog_last) begin
               dog_timeout    = 1'b1;
               dog_cnt_next   = 22'h00_0000;
               grace_next     = 9'h000;
               dog_state_next = dtbw_pkg::DOG_GRACE;
            end
         end
         dtbw_pkg::DOG_GRACE: begin
            grace_next = grace_reg + 9'h001;
            // Repeat timeouts must not restart the grace count, or short intervals never reset
            if (dog_cnt_reg == dog_last) begin
               dog_timeout  = 1'b1;
               dog_cnt_next = 22'h00_0000;
            end
            if (grace_reg == grace_last) begin
               grace_next = 9'h000;
               // Without reset enable the divider simply carries on
               dog_state_next = ewt_reg ? dtbw_pkg::DOG_RESET : dtbw_pkg::DOG_COUNT;
            end
         end
         dtbw_pkg::DOG_RESET: begin
            dog_cnt_next = 22'h00_0000;
            grace_next   = grace_reg + 9'h001;
            if (grace_reg == rst_last) begin
               grace_next     = 9'h000;
               dog_state_next = dtbw_pkg::DOG_COUNT;
            end
         end
         default: begin
            dog_state_next = dtbw_pkg::DOG_IDLE;
         end
      endcase
      if (!dog_run_reg) begin
         dog_state_next = dtbw_pkg::DOG_IDLE;
      end else if (restart && dog_state_reg != dtbw_pkg::DOG_RESET) begin
         dog_cnt_next   = 22'h00_0000;
         grace_next     = 9'h000;
         dog_state_next = dtbw_pkg::DOG_COUNT;
      end
   end

   // Power-on reset leaves the watchdog stopped
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dog_state_reg <= dtbw_pkg::DOG_IDLE;
         dog_cnt_reg   <= 22'h00_0000;
         grace_reg     <= 9'h000;
         dog_rst_reg   <= 1'b0;
      end else begin
         dog_state_reg <= dog_state_next;
         dog_cnt_reg   <= dog_cnt_next;
         grace_reg     <= grace_next;
         dog_rst_reg   <= (dog_state_next == dtbw_pkg::DOG_RESET);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dog_irq_flag_reg    <= 1'b0;
         dog_reset_flag_reg    <= 1'b0;
         ewt_reg     <= 1'b0;
         rwt_reg     <= 1'b0;
         dog_run_reg <= 1'b0;
         dog_int_reg <= 2'h0;
      end else begin
         if (dog_timeout) begin
            dog_irq_flag_reg <= 1'b1;
         end else if (enter_rst) begin
            dog_irq_flag_reg <= 1'b0;
         end else if (wr_wd_ok) begin
            dog_irq_flag_reg <= bus_wdata[dtbw_pkg::WD_IRQ_BIT];
         end
         // Reset entry needs the enable, so only a register write changes the flag while it is low
         if (enter_rst) begin
            dog_reset_flag_reg <= 1'b1;
         end else if (wr_wd) begin
            dog_reset_flag_reg <= bus_wdata[dtbw_pkg::WD_RFLG_BIT];
         end
         if (wr_wd_ok) begin
            ewt_reg     <= bus_wdata[dtbw_pkg::WD_EWT_BIT];
            dog_run_reg <= bus_wdata[dtbw_pkg::WD_RUN_BIT];
         end
         rwt_reg <= restart;
         if (wr_ck) begin
            dog_int_reg <= bus_wdata[dtbw_pkg::CK_INT_LSB +: 2];
         end
      end
   end

   // Control registers, prescaler, tone and synchronisers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tmode_reg   <= dtbw_pkg::RST_BYTE;
         tbase_reg   <= dtbw_pkg::RST_BYTE;
         run_reg     <= 2'h0;
         buz_en_reg  <= 1'b0;
         buz_sel_reg <= 1'b0;
         presc_reg   <= 10'h000;
         buzz_reg    <= 1'b0;
         tone_reg    <= 1'b0;
         sync1_reg   <= 5'h1F;
         sync2_reg   <= 5'h1F;
         sync3_reg   <= 5'h1F;
      end else begin
         if (wr_tmod) begin
            tmode_reg <= bus_wdata;
         end
         if (wr_tb) begin
            tbase_reg <= bus_wdata;
         end
         if (wr_tctl) begin
            run_reg <= bus_wdata[dtbw_pkg::TC_RUN_LSB +: 2];
         end
         if (wr_buz) begin
            buz_en_reg  <= bus_wdata[dtbw_pkg::BZ_EN_BIT];
            buz_sel_reg <= bus_wdata[dtbw_pkg::BZ_SEL_BIT];
         end
         presc_reg <= presc_reg + 10'h001;
         if (ovf_now[0] && t_mode[0] == dtbw_pkg::DTBW_MRLD) begin
            buzz_reg <= ~buzz_reg;
         end
         tone_reg  <= buz_sel_reg ? key_tone : buzz_reg;
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // Read port: data stands in the cycle after the strobe, unmapped reads zero
   wire [7:0] rd_mux =
      (bus_addr == dtbw_pkg::OFF_CNT_LO0) ? cnt_lo_reg[0] :
      (bus_addr == dtbw_pkg::OFF_CNT_HI0) ? cnt_hi_reg[0] :
      (bus_addr == dtbw_pkg::OFF_CNT_LO1) ? cnt_lo_reg[1] :
      (bus_addr == dtbw_pkg::OFF_CNT_HI1) ? cnt_hi_reg[1] :
      (bus_addr == dtbw_pkg::OFF_TMODE)   ? tmode_reg :
      (bus_addr == dtbw_pkg::OFF_TCTL)    ? {2'h0, flag_reg, 2'h0, run_reg} :
      (bus_addr == dtbw_pkg::OFF_TBASE)   ? tbase_reg :
      (bus_addr == dtbw_pkg::OFF_BUZ)     ? {buz_en_reg, buz_sel_reg, 6'h00} :
      (bus_addr == dtbw_pkg::OFF_WATCHDOG_CONTROL)   ? {dog_run_reg, 3'h0, dog_irq_flag_reg, dog_reset_flag_reg, ewt_reg, rwt_reg} :
      (bus_addr == dtbw_pkg::OFF_CLOCK_CONTROL)   ? {dog_int_reg, 6'h00} : 8'h00;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= bus_rd ? rd_mux : 8'h00;
      end
   end

   assign bus_rdata     = rdata_reg;
   assign overflow_flag = flag_reg;
   assign dog_irq_req   = dog_irq_flag_reg & dog_irq_en & global_irq_en;
   assign dog_sys_reset = dog_rst_reg;
   assign tone_out_pin  = tone_reg;
   assign tone_out_oe   = buz_en_reg;

   default clocking dtbw_cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   a_flag_at_phase2: assert property ($rose(flag_reg[0]) |-> $past(phase2) || $past(wr_tctl))
      else $error("overflow flag set outside phase 2");
   a_ack_clears_flag: assert property (ovf_ack[0] && !wr_tctl && !(phase2 && (pend_reg[0] | ovf_now[0]))
      |=> !flag_reg[0])
      else $error("acknowledge did not clear overflow flag");
   a_mode0_carry: assert property (cnt_tick[0] && t_mode[0] == dtbw_pkg::DTBW_M13 && cnt_lo_reg[0][4:0] == 5'h1F
      && !wr_hi0 |=> cnt_hi_reg[0] == $past(cnt_hi_reg[0]) + 8'h01)
      else $error("mode 0 carry into high byte missing");
   a_mode2_reload: assert property (cnt_tick[0] && t_mode[0] == dtbw_pkg::DTBW_MRLD && cnt_lo_reg[0] == 8'hFF
      && !wr_lo0 && !wr_hi0 |=> cnt_lo_reg[0] == cnt_hi_reg[0] && cnt_hi_reg[0] == $past(cnt_hi_reg[0]))
      else $error("mode 2 reload wrong");
   a_gate_holds: assert property (!cnt_en[0] && !wr_lo0 && !wr_hi0 |=> $stable(cnt_lo_reg[0]) && $stable(cnt_hi_reg[0]))
      else $error("timer counted while disabled");
   a_dog_rst_len: assert property ($rose(dog_sys_reset) |-> dog_sys_reset[*8] ##1 !dog_sys_reset)
      else $error("watchdog reset not two machine cycles");
   a_dog_rst_cause: assert property ($rose(dog_sys_reset) |-> $past(ewt_reg) && $past(grace_reg) == grace_last)
      else $error("watchdog reset without enable or early");
   a_dog_flag_set: assert property (dog_timeout |=> dog_irq_flag_reg ##[1:600] (dog_irq_flag_reg || $past(wr_wd_ok) || dog_rst_reg))
      else $error("timeout did not set watchdog flag");
   a_rwt_self_clear: assert property (rwt_reg |=> !rwt_reg || $past(restart))
      else $error("restart bit did not self-clear");
   a_dog_reset_flag_quiet: assert property (!ewt_reg && !wr_wd |=> $stable(dog_reset_flag_reg))
      else $error("reset flag changed with reset disabled");
   a_tone_toggle: assert property (ovf_now[0] && t_mode[0] == dtbw_pkg::DTBW_MRLD |=> buzz_reg != $past(buzz_reg))
      else $error("tone did not toggle on reload");

endmodule // dtbw_top

// file: dtbw_core_model.sv
// Core-side model: timed-access permit and timer service acknowledge
`timescale 1ns/100ps
module dtbw_core_model (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [1:0] overflow_flag,
   input  wire logic       ack_en,
   input  wire logic       unlock,
   output logic      [1:0] ovf_ack,
   output logic            ta_permit
);
   // Acknowledge one cycle after a flag shows, as a core vectoring at once would
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ovf_ack   <= 2'h0;
         ta_permit <= 1'b0;
      end else begin
         ovf_ack   <= ack_en ? (overflow_flag & ~ovf_ack) : 2'h0;
         ta_permit <= unlock;
      end
   end
endmodule // dtbw_core_model

// file: test_dual_timer_buzzer_watchdog.sv
// Testbench: register accesses, timers, tone output and watchdog
`timescale 1ns/100ps
module test_dual_timer_buzzer_watchdog;
   logic                 clk, rstn, bus_wr, bus_rd, ack_en, unlock;
   logic                 dog_irq_en, global_irq_en, key_tone;
   logic [3:0]           bus_addr;
   logic [7:0]           bus_wdata, bus_rdata, d;
   dtbw_pkg::dtbw_pins_t pins;
   logic [1:0]           ovf_ack, overflow_flag;
   logic                 ta_permit, dog_irq_req, dog_sys_reset, tone_out_pin, tone_out_oe, p;
   int                   n_fail, n_compared, cyc, i;
   wire [2:0]            watch = {dog_sys_reset, overflow_flag};

   dtbw_top #(.DOG_INT0(16), .DOG_INT1(32), .DOG_INT2(64), .DOG_INT3(128)) dtbw_top_inst (
      .clk(clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata), .pins(pins), .ta_permit(ta_permit), .ovf_ack(ovf_ack),
      .dog_irq_en(dog_irq_en), .global_irq_en(global_irq_en), .key_tone(key_tone),
      .overflow_flag(overflow_flag), .dog_irq_req(dog_irq_req), .dog_sys_reset(dog_sys_reset),
      .tone_out_pin(tone_out_pin), .tone_out_oe(tone_out_oe));
   dtbw_core_model dtbw_core_model_inst (
      .clk(clk), .rstn(rstn), .overflow_flag(overflow_flag), .ack_en(ack_en), .unlock(unlock),
      .ovf_ack(ovf_ack), .ta_permit(ta_permit));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      bus_wr    <= 1'b1;
      bus_addr  <= a;
      bus_wdata <= v;
      @(posedge clk);
      bus_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      bus_rd   <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_rd   <= 1'b0;
      #1 d = bus_rdata;
   endtask

   task automatic wait_for(input int sel, input int lim);
      for (i = 0; i < lim && watch[sel] !== 1'b1; i++) @(posedge clk) #1;
   endtask

   task automatic wrap_up();
      if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         wrap_up();
      end
   end

   initial begin
      {rstn, bus_wr, bus_rd, ack_en, unlock, dog_irq_en, global_irq_en, key_tone} = 8'h00;
      bus_addr = 4'h0;
      bus_wdata = 8'h00;
      pins = 5'b0_1111;
      n_fail = 0;
      n_compared = 0;
      cyc = 0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      // Reset values, unmapped address included
      for (int a = 0; a < 16; a++) begin
         rd(a[3:0]);
         chk(d, 8'h00);
      end
      // Timer 0 auto-reload, 4 ticks of div4 per overflow
      wr(dtbw_pkg::OFF_CNT_HI0, 8'hFC);
      wr(dtbw_pkg::OFF_CNT_LO0, 8'hFC);
      wr(dtbw_pkg::OFF_TMODE, 8'hD2);
      wr(dtbw_pkg::OFF_TCTL, 8'h01);
      @(posedge clk) #1;
      wait_for(0, 100);
      chk({7'h0, overflow_flag[0]}, 8'h01);
      rd(dtbw_pkg::OFF_CNT_HI0);
      chk(d, 8'hFC);
      rd(dtbw_pkg::OFF_CNT_LO0);
      chk({d[7:2], 2'b00}, 8'hFC);
      // Tone toggles once per reload period
      wr(dtbw_pkg::OFF_BUZ, 8'h80);
      repeat (3) @(posedge clk);
      #1 p = tone_out_pin;
      chk({7'h0, tone_out_oe}, 8'h01);
      repeat (16) @(posedge clk);
      #1 chk({7'h0, tone_out_pin}, {7'h0, ~p});
      @(posedge clk) key_tone <= 1'b1;
      wr(dtbw_pkg::OFF_BUZ, 8'hC0);
      repeat (3) @(posedge clk);
      #1 chk({7'h0, tone_out_pin}, 8'h01);
      wr(dtbw_pkg::OFF_BUZ, 8'h00);
      repeat (3) @(posedge clk);
      #1 chk({7'h0, tone_out_oe}, 8'h00);
      // Service acknowledge clears the flag; timer 0 held so no later overflow sets it again
      wr(dtbw_pkg::OFF_TMODE, 8'hD3);
      wait_for(0, 40);
      @(posedge clk) ack_en <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk({7'h0, overflow_flag[0]}, 8'h00);
      @(posedge clk) ack_en <= 1'b0;
      // Timer 1 counts external edges, held off by the gate pin
      wr(dtbw_pkg::OFF_CNT_HI1, 8'hFF);
      wr(dtbw_pkg::OFF_CNT_LO1, 8'hFF);
      wr(dtbw_pkg::OFF_TCTL, 8'h02);
      pins.ext_irq_pin_n_1 <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         repeat (4) @(posedge clk);
         pins.count_input_1 <= 1'b0;
         repeat (8) @(posedge clk);
         pins.count_input_1 <= 1'b1;
         rd(dtbw_pkg::OFF_CNT_LO1);
         chk(d, k == 0 ? 8'hFF : 8'h00);
         if (k == 1) chk({7'h0, overflow_flag[1]}, 8'h01);
         @(posedge clk) pins.ext_irq_pin_n_1 <= 1'b1;
      end
      // Timer 0 mode 0 on one external edge: carry from bit 4, upper three low bits kept
      wr(dtbw_pkg::OFF_TMODE, 8'hD4);
      wr(dtbw_pkg::OFF_CNT_HI0, 8'hFF);
      wr(dtbw_pkg::OFF_CNT_LO0, 8'hFF);
      wr(dtbw_pkg::OFF_TCTL, 8'h01);
      pins.count_input_0 <= 1'b0;
      repeat (8) @(posedge clk);
      pins.count_input_0 <= 1'b1;
      rd(dtbw_pkg::OFF_CNT_LO0);
      chk(d, 8'hE0);
      rd(dtbw_pkg::OFF_CNT_HI0);
      chk(d, 8'h00);
      chk({7'h0, overflow_flag[0]}, 8'h01);
      // Protected watchdog bits refused without permit
      wr(dtbw_pkg::OFF_WATCHDOG_CONTROL, 8'h82);
      rd(dtbw_pkg::OFF_WATCHDOG_CONTROL);
      chk(d, 8'h00);
      @(posedge clk) unlock <= 1'b1;
      wr(dtbw_pkg::OFF_WATCHDOG_CONTROL, 8'h83);
      unlock <= 1'b0;
      dog_irq_en <= 1'b1;
      repeat (40) @(posedge clk);
      #1 chk({7'h0, dog_irq_req}, 8'h00);
      rd(dtbw_pkg::OFF_WATCHDOG_CONTROL);
      chk(d & 8'h0B, 8'h0A);
      @(posedge clk) global_irq_en <= 1'b1;
      @(posedge clk) #1;
      chk({7'h0, dog_irq_req}, 8'h01);
      wait_for(2, 700);
      for (i = 0; i < 20 && dog_sys_reset === 1'b1; i++) @(posedge clk) #1;
      chk(i[7:0], 8'h08);
      rd(dtbw_pkg::OFF_WATCHDOG_CONTROL);
      chk(d & 8'h86, 8'h86);
      wrap_up();
   end
endmodule // test_dual_timer_buzzer_watchdog
